// ### core/fixed_length_counter_stop.sv
// fixed-length measurement, arrival output and stop logic with apb slave
// Notes on behaviour
// RULE1: count pulses only from code-52 terminals
// RULE2: counted length = pulses / ppr * diameter * pi
// RULE3: actual = counted * ratio / coefficient / 100
// RULE4: actual reaching preset with stop selected stops drive
// RULE5: start refused while actual at or above preset
// RULE6: units digit level/500ms pulse, tens stop/continue
// RULE7: record on arrival: clear, hold, keep counting
// RULE8: record on stop: clear, hold, keep counting
// RULE9: pulses per revolution 1 to 9999, default 1
// RULE10: preset and actual 16-bit meters, reset zero
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "fixed_length_params.svh"
module fixed_length_counter_stop #(
    parameter int unsigned ARRIVE_PULSE_CYC = `FL_ARRIVE_PULSE_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] term_in,
    input wire logic drive_running,
    input wire logic start_req,
    output logic start_grant,
    output logic stop_cmd,
    output logic arrive_out,
    output logic irq
);
    function automatic logic [15:0] sat16(input logic [63:0] q);
        sat16 = (q > 64'h0000_0000_0000_ffff) ? 16'hffff : q[15:0];
    endfunction

    logic [31:0] term_func_ff;
    logic [15:0] preset_ff;
    logic [15:0] actual_ff;
    logic [14:0] ratio_ff;
    logic [9:0] coef_ff;
    logic [13:0] diam_ff;
    logic [13:0] ppr_ff;
    logic arr_unit_ff;
    logic arr_tens_ff;
    logic [1:0] rec_arr_ff;
    logic [1:0] rec_stop_ff;
    logic [1:0] irq_stat_ff;
    logic [1:0] irq_mask_ff;
    logic [31:0] prdata_ff;
    logic [3:0] term_prev_ff;
    logic [23:0] pulse_cnt_ff;
    logic frozen_ff;
    logic hit_prev_ff;
    logic run_prev_ff;
    logic start_grant_ff;
    logic stop_cmd_ff;
    logic arrive_out_ff;
    logic [26:0] pulse_tmr_ff;
    fixed_length_pkg::calc_state_t state_ff;
    logic [5:0] bit_cnt_ff;
    logic [63:0] dvd_ff;
    logic [63:0] den_ff;
    logic [63:0] rem_ff;
    logic [63:0] chk_num_ff;
    logic [63:0] chk_den_ff;

    // apb decode
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire hit_term = paddr == `FL_OFF_TERM_FUNC;
    wire hit_pre = paddr == `FL_OFF_PRESET;
    wire hit_act = paddr == `FL_OFF_ACTUAL;
    wire hit_rat = paddr == `FL_OFF_RATIO;
    wire hit_coef = paddr == `FL_OFF_COEF;
    wire hit_diam = paddr == `FL_OFF_DIAM;
    wire hit_ppr = paddr == `FL_OFF_PPR;
    wire hit_sel = paddr == `FL_OFF_ARR_SEL;
    wire hit_rarr = paddr == `FL_OFF_REC_ARR;
    wire hit_rstp = paddr == `FL_OFF_REC_STOP;
    wire hit_ist = paddr == `FL_OFF_IRQ_STAT;
    wire hit_imsk = paddr == `FL_OFF_IRQ_MASK;
    wire hit_stat = paddr == `FL_OFF_STATUS;
    wire mapped = hit_term || hit_pre || hit_act || hit_rat || hit_coef
        || hit_diam || hit_ppr || hit_sel || hit_rarr || hit_rstp
        || hit_ist || hit_imsk || hit_stat;
    wire wr = access && pwrite && mapped;
    // out-of-range settings are ignored so the divisor never reaches zero
    wire ratio_ok = pwdata[31:15] == 17'h0
        && pwdata[14:0] >= `FL_RATIO_MIN && pwdata[14:0] <= `FL_RATIO_MAX;
    wire coef_ok = pwdata[31:10] == 22'h0
        && pwdata[9:0] >= `FL_COEF_MIN && pwdata[9:0] <= `FL_COEF_MAX;
    wire diam_ok = pwdata[31:14] == 18'h0
        && pwdata[13:0] >= `FL_DIAM_MIN && pwdata[13:0] <= `FL_DIAM_MAX;
    wire ppr_ok = pwdata[31:14] == 18'h0
        && pwdata[13:0] >= `FL_PPR_MIN && pwdata[13:0] <= `FL_PPR_MAX;
    wire rec_ok = pwdata[31:2] == 30'h0 && pwdata[1:0] != 2'h3;

    wire calc_busy = state_ff == fixed_length_pkg::ST_DIV;
    wire [31:0] status_w = {29'h0, calc_busy, frozen_ff, hit_prev_ff};
    wire [31:0] rd_val =
        hit_term ? term_func_ff :
        hit_pre ? {16'h0, preset_ff} :
        hit_act ? {16'h0, actual_ff} :
        hit_rat ? {17'h0, ratio_ff} :
        hit_coef ? {22'h0, coef_ff} :
        hit_diam ? {18'h0, diam_ff} :
        hit_ppr ? {18'h0, ppr_ff} :
        hit_sel ? {27'h0, arr_tens_ff, 3'h0, arr_unit_ff} :
        hit_rarr ? {30'h0, rec_arr_ff} :
        hit_rstp ? {30'h0, rec_stop_ff} :
        hit_ist ? {30'h0, irq_stat_ff} :
        hit_imsk ? {30'h0, irq_mask_ff} :
        hit_stat ? status_w : 32'h0;

    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata = prdata_ff;

    // length pulse detection
    logic [3:0] term_sel;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_term
            assign term_sel[gi] =
                term_func_ff[gi*8 +: 8] == `FL_LEN_FUNC_CODE; // RULE1
        end
    endgenerate
    wire cnt_edge = |(term_in & ~term_prev_ff & term_sel); // RULE1

    // arrival, stop and start decisions
    wire hit = actual_ff >= preset_ff;
    wire arrive_evt = hit && !hit_prev_ff;
    wire stop_evt = run_prev_ff && !drive_running;
    wire sw_clear = wr && hit_act;
    wire arr_clr = arrive_evt
        && rec_arr_ff == fixed_length_pkg::REC_CLEAR; // RULE7
    wire stp_clr = stop_evt
        && rec_stop_ff == fixed_length_pkg::REC_CLEAR; // RULE8
    wire clr_cnt = sw_clear || arr_clr || stp_clr;
    wire hold_set = (arrive_evt
        && rec_arr_ff == fixed_length_pkg::REC_HOLD) // RULE7
        || (stop_evt && rec_stop_ff == fixed_length_pkg::REC_HOLD); // RULE8
    wire grant = start_req && !hit; // RULE5
    wire refuse = start_req && hit; // RULE5
    wire [23:0] nxt_pulse_cnt = clr_cnt ? 24'h0 :
        (cnt_edge && !frozen_ff && pulse_cnt_ff != 24'hffffff)
        ? pulse_cnt_ff + 24'h1 : pulse_cnt_ff;
    wire nxt_frozen = hold_set || (frozen_ff && !sw_clear && !grant);
    wire [26:0] nxt_pulse_tmr = (arrive_evt && arr_unit_ff)
        ? 27'(ARRIVE_PULSE_CYC)
        : (pulse_tmr_ff != 27'h0 ? pulse_tmr_ff - 27'h1 : 27'h0);
    wire nxt_arrive_out = arr_unit_ff
        ? (nxt_pulse_tmr != 27'h0) : hit; // RULE6
    wire [1:0] irq_ev = {refuse, arrive_evt};
    wire [1:0] w1c = (wr && hit_ist) ? pwdata[1:0] : 2'h0;
    wire [1:0] nxt_irq_stat = irq_ev | (irq_stat_ff & ~w1c);
    assign irq = |(irq_stat_ff & irq_mask_ff);
    assign start_grant = start_grant_ff;
    assign stop_cmd = stop_cmd_ff;
    assign arrive_out = arrive_out_ff;

    // length arithmetic, pi taken as 355/113, ratio and coefficient
    // share the same thousandths scale and cancel
    wire [63:0] num_w = 64'(pulse_cnt_ff) * 64'(diam_ff)
        * 64'(ratio_ff) * `FL_PI_NUM; // RULE2
    wire [63:0] den_w = 64'(ppr_ff) * 64'(coef_ff) * `FL_PI_DEN
        * `FL_SCALE_DEN; // RULE3
    wire [64:0] trial = {rem_ff, dvd_ff[63]};
    wire take = trial >= {1'b0, den_ff};
    wire [64:0] diff = trial - {1'b0, den_ff};
    wire [63:0] nxt_rem = take ? diff[63:0] : trial[63:0];
    wire [63:0] nxt_dvd = {dvd_ff[62:0], take};
    wire calc_done = calc_busy && bit_cnt_ff == 6'h3f;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            term_func_ff <= `FL_RST_TERM_FUNC;
            preset_ff <= `FL_RST_PRESET; // RULE10
            ratio_ff <= `FL_RST_RATIO;
            coef_ff <= `FL_RST_COEF;
            diam_ff <= `FL_RST_DIAM;
            ppr_ff <= `FL_RST_PPR; // RULE9
            arr_unit_ff <= 1'b0;
            arr_tens_ff <= 1'b0;
            rec_arr_ff <= `FL_RST_REC;
            rec_stop_ff <= `FL_RST_REC;
            irq_mask_ff <= 2'h0;
            prdata_ff <= 32'h0;
        end else begin
            if (setup) begin
                prdata_ff <= rd_val;
            end
            if (wr && hit_term) begin
                term_func_ff <= pwdata;
            end
            if (wr && hit_pre) begin
                preset_ff <= pwdata[15:0];
            end
            if (wr && hit_rat && ratio_ok) begin
                ratio_ff <= pwdata[14:0];
            end
            if (wr && hit_coef && coef_ok) begin
                coef_ff <= pwdata[9:0];
            end
            if (wr && hit_diam && diam_ok) begin
                diam_ff <= pwdata[13:0];
            end
            if (wr && hit_ppr && ppr_ok) begin
                ppr_ff <= pwdata[13:0]; // RULE9
            end
            if (wr && hit_sel) begin
                arr_unit_ff <= pwdata[`FL_ARR_UNIT_BIT]; // RULE6
                arr_tens_ff <= pwdata[`FL_ARR_TENS_BIT]; // RULE6
            end
            if (wr && hit_rarr && rec_ok) begin
                rec_arr_ff <= pwdata[1:0];
            end
            if (wr && hit_rstp && rec_ok) begin
                rec_stop_ff <= pwdata[1:0];
            end
            if (wr && hit_imsk) begin
                irq_mask_ff <= pwdata[1:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            term_prev_ff <= 4'h0;
            pulse_cnt_ff <= 24'h0;
            frozen_ff <= 1'b0;
            hit_prev_ff <= 1'b0;
            run_prev_ff <= 1'b0;
            start_grant_ff <= 1'b0;
            stop_cmd_ff <= 1'b0;
            arrive_out_ff <= 1'b0;
            pulse_tmr_ff <= 27'h0;
            irq_stat_ff <= 2'h0;
        end else begin
            term_prev_ff <= term_in;
            pulse_cnt_ff <= nxt_pulse_cnt; // RULE7
            frozen_ff <= nxt_frozen;
            hit_prev_ff <= hit;
            run_prev_ff <= drive_running;
            start_grant_ff <= grant; // RULE5
            stop_cmd_ff <= arrive_evt && !arr_tens_ff; // RULE4
            arrive_out_ff <= nxt_arrive_out; // RULE6
            pulse_tmr_ff <= nxt_pulse_tmr;
            irq_stat_ff <= nxt_irq_stat;
        end
    end

    // serial divider: 65 cycles per result (one load, 64 shifts), recomputed continuously
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff <= fixed_length_pkg::ST_IDLE;
            actual_ff <= `FL_RST_ACTUAL; // RULE10
            bit_cnt_ff <= 6'h0;
            dvd_ff <= 64'h0;
            den_ff <= 64'h0;
            rem_ff <= 64'h0;
            chk_num_ff <= 64'h0;
            chk_den_ff <= 64'h1;
        end else if (clr_cnt) begin
            // abort so a stale quotient cannot overwrite the clear
            state_ff <= fixed_length_pkg::ST_IDLE;
            actual_ff <= 16'h0;
        end else begin
            case (state_ff)
                fixed_length_pkg::ST_IDLE: begin
                    state_ff <= fixed_length_pkg::ST_DIV;
                    bit_cnt_ff <= 6'h0;
                    dvd_ff <= num_w;
                    den_ff <= den_w;
                    rem_ff <= 64'h0;
                    chk_num_ff <= num_w;
                    chk_den_ff <= den_w;
                end
                fixed_length_pkg::ST_DIV: begin
                    dvd_ff <= nxt_dvd;
                    rem_ff <= nxt_rem;
                    bit_cnt_ff <= bit_cnt_ff + 6'h1;
                    if (calc_done) begin
                        actual_ff <= sat16(nxt_dvd); // RULE3
                        state_ff <= fixed_length_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= fixed_length_pkg::ST_IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    property p_cnt_src;
        (pulse_cnt_ff > $past(pulse_cnt_ff)) |-> $past(cnt_edge);
    endproperty
    a_cnt_src: assert property (p_cnt_src) // RULE1
        else $error("count rose without a length terminal edge");

    property p_calc;
        (calc_done && !clr_cnt) |=>
            actual_ff == sat16(chk_num_ff / chk_den_ff);
    endproperty
    a_calc: assert property (p_calc) // RULE2
        else $error("actual length differs from formula");

    property p_stop;
        (arrive_evt && !arr_tens_ff) |=> stop_cmd;
    endproperty
    a_stop: assert property (p_stop) // RULE4
        else $error("no stop command on arrival");

    property p_refuse;
        start_req |=> (start_grant == !$past(hit));
    endproperty
    a_refuse: assert property (p_refuse) // RULE5
        else $error("start grant disagrees with length state");

    sequence s_arrive_pulse;
        arrive_evt && arr_unit_ff;
    endsequence
    property p_pulse;
        s_arrive_pulse |=> arrive_out [*8];
    endproperty
    a_pulse: assert property (p_pulse) // RULE6
        else $error("arrival pulse too short");

    property p_level;
        (!arr_unit_ff && $stable(arr_unit_ff) && !$past(rst))
            |-> arrive_out == $past(hit);
    endproperty
    a_level: assert property (p_level) // RULE6
        else $error("level output does not follow arrival");

    sequence s_arr_clear;
        arrive_evt && rec_arr_ff == fixed_length_pkg::REC_CLEAR;
    endsequence
    property p_arr_clear;
        s_arr_clear |=> pulse_cnt_ff == 24'h0 && actual_ff == 16'h0;
    endproperty
    a_arr_clear: assert property (p_arr_clear) // RULE7
        else $error("record not cleared on arrival");

    sequence s_stop_clear;
        stop_evt && rec_stop_ff == fixed_length_pkg::REC_CLEAR;
    endsequence
    property p_stop_clear;
        s_stop_clear |=> pulse_cnt_ff == 24'h0;
    endproperty
    a_stop_clear: assert property (p_stop_clear) // RULE8
        else $error("record not cleared on stop");

    property p_ppr;
        ppr_ff >= `FL_PPR_MIN && ppr_ff <= `FL_PPR_MAX;
    endproperty
    a_ppr: assert property (p_ppr) // RULE9
        else $error("pulses per revolution out of range");

    property p_rst_len;
        $past(rst) |-> preset_ff == 16'h0 && actual_ff == 16'h0;
    endproperty
    a_rst_len: assert property (p_rst_len) // RULE10
        else $error("lengths not zero after reset");
endmodule

// ### include/fixed_length_params.svh
// constants of the fixed-length arrival and stop block
`ifndef FIXED_LENGTH_PARAMS_SVH
`define FIXED_LENGTH_PARAMS_SVH
`define FL_OFF_TERM_FUNC 12'h000
`define FL_OFF_PRESET 12'h004
`define FL_OFF_ACTUAL 12'h008
`define FL_OFF_RATIO 12'h00c
`define FL_OFF_COEF 12'h010
`define FL_OFF_DIAM 12'h014
`define FL_OFF_PPR 12'h018
`define FL_OFF_ARR_SEL 12'h01c
`define FL_OFF_REC_ARR 12'h020
`define FL_OFF_REC_STOP 12'h024
`define FL_OFF_IRQ_STAT 12'h028
`define FL_OFF_IRQ_MASK 12'h02c
`define FL_OFF_STATUS 12'h030
`define FL_LEN_FUNC_CODE 8'h34
`define FL_RST_TERM_FUNC 32'h0000_0000
`define FL_RST_PRESET 16'h0000
`define FL_RST_ACTUAL 16'h0000
`define FL_RST_RATIO 15'h03e8
`define FL_RST_COEF 10'h3e8
`define FL_RST_DIAM 14'h03e8
`define FL_RST_PPR 14'h0001
`define FL_RST_REC 2'h2
`define FL_RATIO_MIN 15'h0001
`define FL_RATIO_MAX 15'h7530
`define FL_COEF_MIN 10'h001
`define FL_COEF_MAX 10'h3e8
`define FL_DIAM_MIN 14'h0064
`define FL_DIAM_MAX 14'h2710
`define FL_PPR_MIN 14'h0001
`define FL_PPR_MAX 14'h270f
`define FL_ARR_UNIT_BIT 0
`define FL_ARR_TENS_BIT 4
`define FL_IRQ_ARRIVE_BIT 0
`define FL_IRQ_REFUSE_BIT 1
`define FL_PI_NUM 64'h0000_0000_0000_0163
`define FL_PI_DEN 64'h0000_0000_0000_0071
`define FL_SCALE_DEN 64'h0000_0000_0000_2710
`define FL_CLK_FREQ_MHZ 200
`define FL_ARRIVE_PULSE_MS 500
`define FL_ARRIVE_PULSE_CYC (`FL_ARRIVE_PULSE_MS * 1000 * `FL_CLK_FREQ_MHZ)
`endif

// ### include/fixed_length_pkg.sv
// types of the fixed-length arrival and stop block
package fixed_length_pkg;
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_DIV = 1'b1
    } calc_state_t;
    typedef enum logic [1:0] {
        REC_CLEAR = 2'b00,
        REC_HOLD = 2'b01,
        REC_COUNT = 2'b10
    } record_mode_t;
endpackage

// ### testbench/shaft_encoder_model.sv
// pulse encoder on the measuring shaft: emits bursts of pulses
`timescale 1ns/1ps
module shaft_encoder_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [7:0] n_pulses,
    output logic pulse_line,
    output logic busy
);
    logic [7:0] left_ff;
    logic [1:0] ph_ff;
    // two cycles low, two high, so every rise is a distinct edge
    assign pulse_line = (left_ff != 8'h00) && ph_ff[1];
    assign busy = (left_ff != 8'h00);
    always @(posedge core_clk) begin
        if (rst) begin
            left_ff <= 8'h00;
            ph_ff <= 2'h0;
        end else if (go && left_ff == 8'h00) begin
            left_ff <= n_pulses;
            ph_ff <= 2'h0;
        end else if (left_ff != 8'h00) begin
            ph_ff <= ph_ff + 2'h1;
            if (ph_ff == 2'h3) begin
                left_ff <= left_ff - 8'h01;
            end
        end
    end
endmodule

// ### testbench/tb_fixed_length_counter_stop.sv
// self-checking bench: apb register traffic and encoder bursts
`timescale 1ns/1ps
`include "fixed_length_params.svh"
module tb_fixed_length_counter_stop;
    localparam int unsigned PCYC = 20;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic drive_running = 1'b0;
    logic start_req = 1'b0;
    logic start_grant, stop_cmd, arrive_out, irq;
    logic go = 1'b0;
    logic on_t1 = 1'b0;
    logic [7:0] n_p = 8'h00;
    logic line, busy;
    logic [31:0] rd_q;
    logic err_q;
    int n_mismatch = 0;
    int num_checks = 0;
    int n_stop = 0;
    int n_hi = 0;
    int n_gr = 0;
    int i, s, h;
    // terminal 0 keeps code 0, terminal 1 gets the length-count code
    wire logic [3:0] term_in = {2'b00, line & on_t1, line & ~on_t1};

    always #2.5 core_clk = ~core_clk;

    fixed_length_counter_stop #(.ARRIVE_PULSE_CYC(PCYC)) uut (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .term_in(term_in),
        .drive_running(drive_running), .start_req(start_req),
        .start_grant(start_grant), .stop_cmd(stop_cmd),
        .arrive_out(arrive_out), .irq(irq)
    );
    shaft_encoder_model enc (
        .core_clk(core_clk), .rst(rst), .go(go), .n_pulses(n_p),
        .pulse_line(line), .busy(busy)
    );

    // running tallies; scenarios compare differences, not absolutes
    always @(posedge core_clk) begin
        if (stop_cmd === 1'b1) n_stop <= n_stop + 1;
        if (arrive_out === 1'b1) n_hi <= n_hi + 1;
        if (start_grant === 1'b1) n_gr <= n_gr + 1;
    end

    task automatic test_done;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tmo;
        if (i >= 400) begin
            chk(32'h0, 32'h1);
            test_done;
        end
    endtask

    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        i = 0;
        @(posedge core_clk);
        while (pready !== 1'b1 && i < 400) begin
            @(posedge core_clk);
            i++;
        end
        tmo;
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd_q, e);
    endtask

    task automatic burst(input logic t1, input logic [7:0] n);
        @(posedge core_clk);
        on_t1 <= t1;
        n_p <= n;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        i = 0;
        @(posedge core_clk);
        while (busy === 1'b1 && i < 400) begin
            @(posedge core_clk);
            i++;
        end
        tmo;
        // divide result lands within about 130 cycles of the last count
        repeat (250) @(posedge core_clk);
    endtask

    task automatic strt;
        @(posedge core_clk);
        start_req <= 1'b1;
        @(posedge core_clk);
        start_req <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    // settings used below: ratio 30000, coef 1, diam 100, ppr 1
    // diameter in 0.01 cm: one /100 to cm, one /100 of the formula
    function automatic logic [31:0] len(input logic [63:0] c);
        logic [63:0] q;
        q = c * 64'h64 * 64'h7530 * 64'h163 / (64'h71 * 64'h2710);
        return (q > 64'hffff) ? 32'hffff : {16'h0, q[15:0]};
    endfunction

    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        rchk(`FL_OFF_PRESET, 32'h0);
        rchk(`FL_OFF_ACTUAL, 32'h0);
        rchk(`FL_OFF_PPR, 32'h1);
        rchk(`FL_OFF_REC_ARR, 32'h2);
        rchk(`FL_OFF_REC_STOP, 32'h2);
        bus(1'b0, 12'h0fc, 32'h0);
        chk({31'h0, err_q}, 32'h1);
        chk({31'h0, pready}, 32'h1);
        bus(1'b1, `FL_OFF_PPR, 32'h0);
        bus(1'b1, `FL_OFF_PPR, 32'h2710);
        rchk(`FL_OFF_PPR, 32'h1);
        bus(1'b1, `FL_OFF_PPR, 32'h270f);
        rchk(`FL_OFF_PPR, 32'h270f);
        bus(1'b1, `FL_OFF_PPR, 32'h1);
        bus(1'b1, `FL_OFF_RATIO, 32'h7530);
        bus(1'b1, `FL_OFF_COEF, 32'h1);
        bus(1'b1, `FL_OFF_DIAM, 32'h64);
        bus(1'b1, `FL_OFF_PRESET, 32'hffff);
        bus(1'b1, `FL_OFF_TERM_FUNC, 32'h3400);
        bus(1'b1, `FL_OFF_ACTUAL, 32'h0);
        bus(1'b1, `FL_OFF_IRQ_STAT, 32'h3);
        burst(1'b0, 8'h03);
        rchk(`FL_OFF_ACTUAL, 32'h0);
        burst(1'b1, 8'h02);
        rchk(`FL_OFF_ACTUAL, len(2));
        bus(1'b1, `FL_OFF_PRESET, 32'h7d0);
        bus(1'b1, `FL_OFF_IRQ_MASK, 32'h3);
        bus(1'b1, `FL_OFF_ACTUAL, 32'h0);
        s = n_stop;
        burst(1'b1, 8'h03);
        chk(n_stop - s, 1);
        chk({31'h0, arrive_out}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, `FL_OFF_IRQ_MASK, 32'h0);
        // the mask write lands at the edge the task returns on
        @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, `FL_OFF_IRQ_MASK, 32'h3);
        s = n_gr;
        strt;
        chk(n_gr - s, 0);
        rchk(`FL_OFF_IRQ_STAT, 32'h3);
        bus(1'b1, `FL_OFF_ACTUAL, 32'h0);
        bus(1'b1, `FL_OFF_IRQ_STAT, 32'h3);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        strt;
        chk(n_gr - s, 1);
        bus(1'b1, `FL_OFF_ARR_SEL, 32'h11);
        bus(1'b1, `FL_OFF_REC_ARR, 32'h0);
        s = n_stop;
        h = n_hi;
        burst(1'b1, 8'h03);
        chk(n_hi - h, PCYC);
        chk(n_stop - s, 0);
        rchk(`FL_OFF_ACTUAL, 32'h0);
        bus(1'b1, `FL_OFF_REC_ARR, 32'h2);
        bus(1'b1, `FL_OFF_REC_STOP, 32'h0);
        bus(1'b1, `FL_OFF_PRESET, 32'hffff);
        drive_running <= 1'b1;
        burst(1'b1, 8'h02);
        rchk(`FL_OFF_ACTUAL, len(2));
        drive_running <= 1'b0;
        repeat (250) @(posedge core_clk);
        rchk(`FL_OFF_ACTUAL, 32'h0);
        bus(1'b1, `FL_OFF_REC_ARR, 32'h1);
        bus(1'b1, `FL_OFF_PRESET, 32'h7d0);
        bus(1'b1, `FL_OFF_ACTUAL, 32'h0);
        burst(1'b1, 8'h03);
        // hold mode: pulses after arrival must not count
        burst(1'b1, 8'h02);
        rchk(`FL_OFF_ACTUAL, len(3));
        test_done;
    end
endmodule
